// ---- pcs_pkg.sv ----
// Package for the pattern checker statistics block: register map,
// field positions, reset values and the checker event carrier.
// Assumes a 32-bit APB slave with word-aligned registers.
package pcs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] PCS_IDX_TEST_CTRL = 10'h016;
  localparam logic [9:0] PCS_IDX_BYTE_TOT  = 10'h071;
  localparam logic [9:0] PCS_IDX_ERR_CTRL  = 10'h072;

  // Byte addresses derived from the indices
  localparam logic [11:0] PCS_ADDR_TEST_CTRL = {PCS_IDX_TEST_CTRL, 2'b00};
  localparam logic [11:0] PCS_ADDR_BYTE_TOT  = {PCS_IDX_BYTE_TOT, 2'b00};
  localparam logic [11:0] PCS_ADDR_ERR_CTRL  = {PCS_IDX_ERR_CTRL, 2'b00};

  // Field positions in the error and control register
  localparam int PCS_BIT_LOCK     = 0;
  localparam int PCS_BIT_CLEAR    = 1;
  localparam int PCS_BIT_BYTE_OVF = 9;
  localparam int PCS_BIT_PKT_OVF  = 10;
  // Field position of the saturate select in the test control register
  localparam int PCS_BIT_SAT_SEL  = 0;

  // Counter widths
  localparam int PCS_BYTE_W = 16;
  localparam int PCS_ERR_W  = 8;
  localparam int PCS_PKT_W  = 16;

  // Values after reset
  localparam logic [15:0] PCS_BYTE_RST = 16'h0000;
  localparam logic [7:0]  PCS_ERR_RST  = 8'h00;
  localparam logic        PCS_SAT_RST  = 1'b0;
  localparam logic [31:0] PCS_RDATA_RST = 32'h0000_0000;

  // One received byte as reported by the pattern checker
  typedef struct packed {
    logic valid;     // A byte was received this cycle
    logic error;     // That byte did not match the pattern
    logic pkt_end;   // That byte closed a packet
  } pcs_rx_s;

endpackage : pcs_pkg

// ---- pcs_top.sv ----
// Statistics logic of the pattern checker: byte, error and packet
// tallies, freeze and clear controls and overflow flags over APB.
// Assumes checker events synchronous to pclk, one byte per cycle at most.
// Notes on behaviour
// R1: Sixteen-bit received byte tally, starts at zero.
// R2: Saturate mode: byte tally stops at maximum.
// R3: Eight-bit errored byte tally in low byte.
// R4: Saturate mode: error tally holds at maximum.
// R5: Writing bit 0 freezes tallies for reading.
// R6: Writing bit 1 freezes and clears tallies.
// R7: Packet tally overflow sets sticky bit 10.
// R8: Byte tally overflow sets sticky bit 9.
// R9: Clearing via bit 1 drops both flags.
// R10: Bits 15 to 11 and 8 read zero.
// R11: Wrap mode: tallies roll over, byte and packet tallies flag overflow.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps

// One tally: counts, saturates or wraps, reports overflow
module pcs_tally #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         inc,
  input  wire logic         clr,
  input  wire logic         wrap_en,
  // Result
  output logic [W-1:0]      count,
  output logic              ovf
);
  localparam logic [W-1:0] CNT_MAX = '1;  // All ones
  localparam logic [W-1:0] CNT_ONE = W'(1);

  logic at_max;                          // Tally sits at its maximum

  assign at_max = (count == CNT_MAX);
  // An increment at the maximum overflows, in both modes
  assign ovf = inc && !clr && at_max;

  // Tally register; a byte arriving with the clear is counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clr) begin
      count <= inc ? CNT_ONE : '0;
    end else if (inc && !at_max) begin
      count <= count + CNT_ONE;
    end else if (inc && wrap_en) begin
      count <= '0;
    end
  end
endmodule // pcs_tally

// Top: APB slave and the checker statistics
module pcs_top #(
  parameter int AW = 12   // APB address width
) (
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [AW-1:0]  paddr,
  input  wire logic [31:0]    pwdata,
  input  wire logic [3:0]     pstrb,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // Checker events
  input  wire pcs_pkg::pcs_rx_s rx_evt
);
  import pcs_pkg::*;

  logic                  sat_sel_reg;     // 1 = wrap, 0 = saturate
  logic [PCS_BYTE_W-1:0] byte_snap_reg;   // Frozen byte tally
  logic [PCS_ERR_W-1:0]  err_snap_reg;    // Frozen error tally
  logic                  byte_ovf_reg;    // Sticky byte overflow
  logic                  pkt_ovf_reg;     // Sticky packet overflow
  logic [31:0]           rdata_next;      // Read data for this address
  logic                  hit_next;        // Address is mapped
  logic                  apb_done;        // Transfer completes now
  logic                  wr_done;         // Write completes now
  logic                  sel_ctrl;        // Test control selected
  logic                  sel_byte;        // Byte total selected
  logic                  sel_err;         // Error and control selected
  logic                  lock_pls;        // Freeze the tallies
  logic                  clr_pls;         // Clear tallies and flags
  logic [PCS_BYTE_W-1:0] byte_cnt;        // Live byte tally
  logic [PCS_ERR_W-1:0]  err_cnt;         // Live error tally
  logic [PCS_PKT_W-1:0]  pkt_cnt;         // Live packet tally
  logic                  byte_ovf;        // Byte tally overflow event
  logic                  err_ovf;         // Error tally overflow event
  logic                  pkt_ovf;         // Packet tally overflow event

  // Address decode on the full byte address
  assign sel_ctrl = (paddr == AW'(PCS_ADDR_TEST_CTRL));
  assign sel_byte = (paddr == AW'(PCS_ADDR_BYTE_TOT));
  assign sel_err  = (paddr == AW'(PCS_ADDR_ERR_CTRL));

  // A transfer ends at the edge where pready is sampled high
  assign apb_done = psel && penable && pready;
  assign wr_done  = apb_done && pwrite;

  // Control strobes from a write of the error and control register
  assign lock_pls = wr_done && sel_err && pstrb[0]
                    && (pwdata[PCS_BIT_LOCK] || pwdata[PCS_BIT_CLEAR]); // R5
  assign clr_pls  = wr_done && sel_err && pstrb[0]
                    && pwdata[PCS_BIT_CLEAR];                          // R6

  // Received byte tally
  pcs_tally #(.W(PCS_BYTE_W)) u_byte (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (rx_evt.valid),             // R1
    .clr     (clr_pls),                  // R6
    .wrap_en (sat_sel_reg),              // R2 R11
    .count   (byte_cnt),
    .ovf     (byte_ovf)
  );

  // Errored byte tally
  pcs_tally #(.W(PCS_ERR_W)) u_err (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (rx_evt.valid && rx_evt.error), // R3
    .clr     (clr_pls),                  // R6
    .wrap_en (sat_sel_reg),              // R4 R11
    .count   (err_cnt),
    .ovf     (err_ovf)
  );

  // Packet tally, seen only through its overflow flag
  pcs_tally #(.W(PCS_PKT_W)) u_pkt (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (rx_evt.valid && rx_evt.pkt_end),
    .clr     (clr_pls),
    .wrap_en (sat_sel_reg),
    .count   (pkt_cnt),
    .ovf     (pkt_ovf)
  );

  // Saturate select, written through the test control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_sel_reg <= PCS_SAT_RST;
    end else if (wr_done && sel_ctrl && pstrb[0]) begin
      sat_sel_reg <= pwdata[PCS_BIT_SAT_SEL];
    end
  end

  // Freeze: snapshot taken before any clear of the same write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_snap_reg <= PCS_BYTE_RST;
      err_snap_reg  <= PCS_ERR_RST;
    end else if (lock_pls) begin
      byte_snap_reg <= byte_cnt;         // R5
      err_snap_reg  <= err_cnt;          // R5
    end
  end

  // Sticky overflow flags; clear cannot meet an overflow event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_ovf_reg <= 1'b0;
      pkt_ovf_reg  <= 1'b0;
    end else begin
      byte_ovf_reg <= byte_ovf || (byte_ovf_reg && !clr_pls); // R8 R9 R11
      pkt_ovf_reg  <= pkt_ovf || (pkt_ovf_reg && !clr_pls);   // R7 R9
    end
  end

  // Read mux; reserved bits and upper half read zero
  always_comb begin
    rdata_next = '0;
    hit_next   = 1'b1;
    if (sel_ctrl) begin
      rdata_next[PCS_BIT_SAT_SEL] = sat_sel_reg;
    end else if (sel_byte) begin
      rdata_next[PCS_BYTE_W-1:0] = byte_snap_reg;         // R1
    end else if (sel_err) begin
      rdata_next[PCS_ERR_W-1:0] = err_snap_reg;           // R3 R10
      rdata_next[PCS_BIT_BYTE_OVF] = byte_ovf_reg;        // R8
      rdata_next[PCS_BIT_PKT_OVF]  = pkt_ovf_reg;         // R7
    end else begin
      hit_next = 1'b0;                   // Unmapped address
    end
  end

  // APB answer: one wait state, data and error with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= PCS_RDATA_RST;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? '0 : rdata_next;
      pslverr <= !hit_next;
    end else begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Tally behaviour: stepping, holding, saturating and wrapping

  // A byte below the maximum steps the byte tally by one
  byte_inc_a: assert property (rx_evt.valid && !clr_pls && (&byte_cnt) == 1'b0 // R1
    |=> byte_cnt == PCS_BYTE_W'($past(byte_cnt) + 1))
    else $error("byte tally did not step");

  // With no byte and no clear the byte tally stands still
  byte_idle_a: assert property (!rx_evt.valid && !clr_pls // R1
    |=> $stable(byte_cnt))
    else $error("byte tally moved without a byte");

  // A byte at the maximum in saturate mode holds and flags
  byte_sat_a: assert property (rx_evt.valid && !sat_sel_reg && !clr_pls && (&byte_cnt) // R2
    |=> (&byte_cnt) && byte_ovf_reg)
    else $error("byte tally left its maximum in saturate mode");

  // In saturate mode the maximum is kept until a clear
  byte_max_a: assert property (!sat_sel_reg && !clr_pls && (&byte_cnt) // R2
    |=> (&byte_cnt))
    else $error("byte tally dropped from its maximum");

  // An errored byte below the maximum steps the error tally
  err_inc_a: assert property (rx_evt.valid && rx_evt.error && !clr_pls // R3
    && !(&err_cnt) |=> err_cnt == PCS_ERR_W'($past(err_cnt) + 1))
    else $error("error tally did not step");

  // Clean bytes leave the error tally alone
  err_idle_a: assert property (!(rx_evt.valid && rx_evt.error) && !clr_pls // R3
    |=> $stable(err_cnt))
    else $error("error tally moved without an error");

  // In saturate mode the error tally holds at its maximum
  err_sat_a: assert property (!sat_sel_reg && !clr_pls && (&err_cnt) // R4
    |=> (&err_cnt))
    else $error("error tally left its maximum in saturate mode");

  // In wrap mode an error at the maximum rolls over to zero
  err_wrap_a: assert property (sat_sel_reg && rx_evt.valid && rx_evt.error // R11
    && !clr_pls && (&err_cnt) |=> err_cnt == PCS_ERR_RST)
    else $error("error tally did not wrap");

  // In wrap mode a byte at the maximum rolls over and flags
  byte_wrap_a: assert property (sat_sel_reg && rx_evt.valid && !clr_pls // R11
    && (&byte_cnt) |=> byte_cnt == PCS_BYTE_RST && byte_ovf_reg)
    else $error("byte tally did not wrap with overflow");

  // Freeze and clear controls

  // Freeze copies the tallies and keeps them running
  lock_keep_a: assert property (lock_pls && !clr_pls && !rx_evt.valid // R5
    |=> byte_snap_reg == $past(byte_cnt) && byte_cnt == $past(byte_cnt)
    && err_snap_reg == $past(err_cnt))
    else $error("freeze lost or cleared the tallies");

  // Without a freeze the snapshots do not change
  snap_hold_a: assert property (!lock_pls // R5
    |=> $stable(byte_snap_reg) && $stable(err_snap_reg))
    else $error("snapshot changed without a freeze");

  // Clear freezes first, then zeroes, counting a byte in that cycle
  clear_snap_a: assert property (clr_pls // R6
    |=> byte_snap_reg == $past(byte_cnt)
    && err_cnt == PCS_ERR_W'($past(rx_evt.valid && rx_evt.error))
    && byte_cnt == PCS_BYTE_W'($past(rx_evt.valid)))
    else $error("clear did not freeze and zero the tallies");

  // Overflow flags

  // Packet overflow flag stays up until a clear
  pkt_flag_a: assert property ((pkt_ovf || pkt_ovf_reg) && !clr_pls // R7
    |=> pkt_ovf_reg [*1] ##1 (pkt_ovf_reg || $past(clr_pls)))
    else $error("packet overflow flag not sticky");

  // Packet overflow flag rises only on a packet overflow
  pkt_rise_a: assert property ($rose(pkt_ovf_reg) // R7
    |-> $past(pkt_ovf))
    else $error("packet overflow flag rose without cause");

  // Byte overflow flag rises only on an increment at maximum
  byte_flag_a: assert property ($rose(byte_ovf_reg) // R8
    |-> $past(byte_ovf) && $past(&byte_cnt))
    else $error("byte overflow flag rose without cause");

  // Byte overflow flag stays up until a clear
  byte_stick_a: assert property (byte_ovf_reg && !clr_pls // R8
    |=> byte_ovf_reg)
    else $error("byte overflow flag not sticky");

  // A clear drops both flags
  flag_clear_a: assert property (clr_pls // R9
    |=> !byte_ovf_reg && !pkt_ovf_reg)
    else $error("clear left an overflow flag set");

  // Register reads and writes

  // Flags read live in bits 9 and 10
  flag_read_a: assert property (pready && $past(sel_err) && !$past(pwrite) // R7 R8
    |-> prdata[PCS_BIT_BYTE_OVF] == $past(byte_ovf_reg)
    && prdata[PCS_BIT_PKT_OVF] == $past(pkt_ovf_reg))
    else $error("overflow flags read wrong");

  // Reserved bits of the error and control register read zero
  resv_zero_a: assert property (pready && $past(sel_err) && !$past(pwrite) // R10
    |-> prdata[15:11] == 5'h00 && !prdata[8] && prdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");

  // Byte total reads the frozen tally in the low half
  byte_read_a: assert property (pready && $past(sel_byte) && !$past(pwrite) // R1
    |-> prdata == {16'h0000, $past(byte_snap_reg)})
    else $error("byte total read wrong");

  // Test control reads only the saturate select
  ctrl_zero_a: assert property (pready && $past(sel_ctrl) && !$past(pwrite)
    |-> prdata[31:1] == 31'h0000_0000 && prdata[0] == $past(sat_sel_reg))
    else $error("test control read wrong");

  // A completed control write lands in the saturate select
  sat_write_a: assert property (wr_done && sel_ctrl && pstrb[0]
    |=> sat_sel_reg == $past(pwdata[PCS_BIT_SAT_SEL]))
    else $error("saturate select write lost");

  // Bus answer timing and response

  // The answer comes after exactly one wait state
  apb_wait_a: assert property (psel && penable && !pready
    |=> pready ##1 !pready)
    else $error("answer not after one wait state");

  // Read data is zero outside the answer cycle
  rdata_idle_a: assert property (!pready
    |-> prdata == PCS_RDATA_RST)
    else $error("read data stands outside the answer");

  // Writes answer with zero data
  wr_data_a: assert property (pready && $past(pwrite)
    |-> prdata == PCS_RDATA_RST)
    else $error("write answered with data");

  // Error response only for addresses outside the map
  slverr_a: assert property (pready
    |-> pslverr == !$past(sel_ctrl || sel_byte || sel_err))
    else $error("error response wrong for address");

  // Main scenarios
  lock_c:  cover property (lock_pls && !clr_pls);
  clear_c: cover property (clr_pls && byte_ovf_reg);
  wrap_c:  cover property (byte_ovf && sat_sel_reg);
  sat_c:   cover property (err_ovf && !sat_sel_reg);
  read_c:  cover property (pready && !pslverr && !$past(pwrite));

endmodule // pcs_top

// ---- pcs_top_tb.sv ----
// Self-checking testbench for the pattern checker statistics block.
// Assumes pcs_pkg and pcs_top are compiled first; APB master and
// checker byte events are driven here by non-blocking assignment.
`timescale 1ns/100ps

module pcs_top_tb;
  import pcs_pkg::*;

  // Bench limits
  localparam int TMO_CYC = 90000;   // Ceiling on run length in cycles

  logic          pclk;              // Core clock, 40 ns period
  logic          presetn;           // Asynchronous reset, active low
  logic          psel;              // APB select
  logic          penable;           // APB access phase
  logic          pwrite;            // APB direction
  logic [11:0]   paddr;             // APB byte address
  logic [31:0]   pwdata;            // APB write data
  logic [3:0]    pstrb;             // APB byte strobes
  logic [31:0]   prdata;            // APB read data
  logic          pready;            // APB completion
  logic          pslverr;           // APB error response
  pcs_rx_s       rx_evt;            // Checker byte event
  int            err_total;         // Mismatches seen
  int            num_checks;        // Comparisons made
  int            cyc;               // Cycles since start
  logic [31:0]   rd_val;            // Last read data
  logic          rd_err;            // Last error response

  pcs_top #(.AW(12)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt)
  );

  // Clock generation
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Compare one value and count the outcome
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_val = prdata;
    rd_err = pslverr;
    if (n >= 50) chk("pready wait", 32'h0, 32'h1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Register write and checked read
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd_val, exp);
  endtask

  // Stream n bytes with the given error and packet-end flags
  task automatic send(input int n, input logic e, input logic p);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_evt <= '{1'b1, e, p};
    end
    @(posedge pclk);
    rx_evt <= '0;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == TMO_CYC) begin
      err_total++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    err_total = 0; num_checks = 0; cyc = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; rx_evt = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Values after reset
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_0000, "byte total reset");
    rd(PCS_ADDR_ERR_CTRL, 32'h0000_0000, "error reg reset");
    $display("test reset done");
    // Freeze only: snapshot holds, tallies keep running
    send(5, 1'b0, 1'b1);
    send(3, 1'b1, 1'b0);
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0001);
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_0008, "byte total frozen");
    rd(PCS_ADDR_ERR_CTRL, 32'h0000_0003, "error frozen");
    send(4, 1'b1, 1'b0);
    wr(PCS_ADDR_BYTE_TOT, 32'h0000_ffff);
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_0008, "byte total held");
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0001);
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_000c, "byte total uncleared");
    rd(PCS_ADDR_ERR_CTRL, 32'h0000_0007, "error uncleared");
    $display("test freeze done");
    // Freeze and clear
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0002);
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_000c, "byte total at clear");
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0001);
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_0000, "byte total cleared");
    rd(PCS_ADDR_ERR_CTRL, 32'h0000_0000, "error cleared");
    $display("test clear done");
    // Unmapped address and control readback
    rd(12'h000, 32'h0000_0000, "unmapped data");
    chk("unmapped error", {31'h0, rd_err}, 32'h1);
    wr(PCS_ADDR_TEST_CTRL, 32'h0000_0001);
    rd(PCS_ADDR_TEST_CTRL, 32'h0000_0001, "saturate select");
    wr(PCS_ADDR_TEST_CTRL, 32'h0000_0000);
    rd(PCS_ADDR_TEST_CTRL, 32'h0000_0000, "saturate select");
    $display("test access done");
    // Saturate mode: errored packet-end bytes, two past the byte and packet maximum
    send(65537, 1'b1, 1'b1);
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0001);
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_ffff, "byte total saturated");
    rd(PCS_ADDR_ERR_CTRL, 32'h0000_06ff, "error and flags");
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0002);
    rd(PCS_ADDR_ERR_CTRL, 32'h0000_00ff, "flags cleared");
    $display("test saturate done");
    // Wrap mode: error tally rolls over
    wr(PCS_ADDR_TEST_CTRL, 32'h0000_0001);
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0002);
    send(257, 1'b1, 1'b0);
    wr(PCS_ADDR_ERR_CTRL, 32'h0000_0001);
    rd(PCS_ADDR_BYTE_TOT, 32'h0000_0101, "byte total wrap");
    rd(PCS_ADDR_ERR_CTRL, 32'h0000_0001, "error wrapped");
    $display("test wrap done");
    final_report();
  end

endmodule // pcs_top_tb
